// ==== hw/bus_pin_sync.sv ====
// Purpose: Brings the clock, data and reset pins into the mclk domain.
// Assumes: Pins are asynchronous to mclk; mclk is far faster than the serial clock.
// Notes:   Only the second stage of each synchroniser is read by logic.
`timescale 1ns/1ps
module bus_pin_sync (
  input  wire logic                     mclk,
  input  wire logic                     srst,
  input  wire logic                     scl_in,
  input  wire logic                     sda_in,
  input  wire logic                     hardware_reset_pin_n,
  output led_i2c_pkg::bus_events_t      events
);
  import led_i2c_pkg::*;

  logic [2:0] meta_q;
  logic [2:0] meta_d;
  logic [2:0] sync_q;
  logic [2:0] sync_d;
  logic [1:0] last_q;
  logic [1:0] last_d;

  // --------------------------------------------------------------------------
  // Two-stage synchronisers and history of the line levels
  // --------------------------------------------------------------------------
  always_comb begin
    meta_d = {hardware_reset_pin_n, sda_in, scl_in};
    sync_d = meta_q;
    last_d = sync_q[1:0];
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      meta_q <= 3'h7;
      sync_q <= 3'h7;
      last_q <= 2'h3;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      last_q <= last_d;
    end
  end

  // --------------------------------------------------------------------------
  // Edge and condition detection
  // --------------------------------------------------------------------------
  always_comb begin
    events.scl         = sync_q[0];
    events.sda         = sync_q[1];
    events.reset_pin_n = sync_q[2];
    events.scl_rise    = sync_q[0] & ~last_q[0];
    events.scl_fall    = ~sync_q[0] & last_q[0];
    events.start       = sync_q[0] & last_q[0] & last_q[1] & ~sync_q[1]; // RL2
    events.stop        = sync_q[0] & last_q[0] & ~last_q[1] & sync_q[1]; // RL3
  end

endmodule

// ==== hw/led_i2c_cfg.svh ====
// Purpose: Offsets, field positions and reset values of the LED driver register port.
// Assumes: Included by bare name from the register port, the bench and the checker files.
// Notes:   Definitions only.
`ifndef LED_I2C_CFG_SVH
`define LED_I2C_CFG_SVH

// ----------------------------------------------------------------------------
// Chip address and direction
// ----------------------------------------------------------------------------
`define CHIP_ADDR          7'h36
`define DIR_WRITE          1'b0
`define DIR_READ           1'b1
`define BYTE_BITS          4'h8

// ----------------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------------
`define IDX_GROUP_ENABLE   8'h10
`define IDX_RAMP_STEP      8'h20
`define IDX_VF_MON_DELAY   8'h60
`define IDX_MAIN_BRIGHT    8'ha0
`define IDX_AUX_BRIGHT     8'hb0
`define IDX_IND_BRIGHT     8'hc0

// ----------------------------------------------------------------------------
// Power-on values
// ----------------------------------------------------------------------------
`define RST_GROUP_ENABLE   8'h00
`define RST_RAMP_STEP      8'hf0
`define RST_VF_MON_DELAY   8'hfc
`define RST_MAIN_BRIGHT    8'he0
`define RST_AUX_BRIGHT     8'hf8
`define RST_IND_BRIGHT     8'hf8

// ----------------------------------------------------------------------------
// Fields of the group enable and assignment register
// ----------------------------------------------------------------------------
`define BIT_MAIN_ON        0
`define BIT_AUX_ON         1
`define BIT_IND_ON         2
`define BIT_SINK53_MAIN    3
`define BIT_SINK62_MAIN    4

`endif

// ==== hw/led_i2c_pkg.sv ====
// Purpose: Types shared by the LED driver register port.
// Assumes: Constants come from led_i2c_cfg.svh.
// Notes:   Types only.
package led_i2c_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_TX_ACK,
    ST_IGNORE
  } state_t;

  typedef enum logic [1:0] {
    KIND_ADDR,
    KIND_INDEX,
    KIND_DATA
  } byte_kind_t;

  typedef struct packed {
    logic [7:0] group_enable_and_assign;
    logic [7:0] ramp_step_time;
    logic [7:0] forward_voltage_monitor_delay;
    logic [7:0] main_group_brightness;
    logic [7:0] aux_group_brightness;
    logic [7:0] indicator_brightness;
  } reg_bank_t;

  typedef struct packed {
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic reset_pin_n;
  } bus_events_t;

endpackage

// ==== hw/led_i2c_regs.sv ====
// Purpose: Serial register port and register bank of an eight-sink LED driver.
// Assumes: The serial clock runs far slower than mclk; the data pin is open drain.
// Notes:   The serial clock and data are oversampled; no clock is taken from the pins.
//          A read returns the register at the last written index; unknown
//          indices read as zero and further read bytes repeat that register.
//          The reset pin overrides start and stop, which override the
//          byte-level protocol state.
//
// How it works
// RL1 - Data changes only while serial clock low.
// RL2 - Master starts: data falls, clock high.
// RL3 - Master stops: data rises, clock high.
// RL4 - Bus busy from start until stop.
// RL5 - Repeated start restarts address reception.
// RL6 - Eight bits MSB first, then acknowledge.
// RL7 - Master clocks and releases acknowledge slot.
// RL8 - Device pulls data low on ninth pulse.
// RL9 - First byte: seven-bit address plus direction.
// RL10 - Respond only to chip address 36h.
// RL11 - Direction zero writes, one reads.
// RL12 - Second write byte is register index.
// RL13 - Third write byte stored in indexed register.
// RL14 - Reset pin low clears all registers; code loads power-on values.
// RL15 - Enable bits switch main, aux, indicator drivers.
// RL16 - Assignment bit one: main group, zero: aux.
// RL17 - Foreign address: stay released until start.
// RL18 - Unknown index changes no register.
`timescale 1ns/1ps
`include "led_i2c_cfg.svh"
module led_i2c_regs (
  input  wire logic                     mclk,
  input  wire logic                     srst,
  input  wire logic                     scl_in,
  input  wire logic                     sda_in,
  output logic                          sda_out,
  output logic                          sda_oe,
  input  wire logic                     hardware_reset_pin_n,
  output led_i2c_pkg::reg_bank_t        regs,
  output logic                          bus_busy,
  output logic                          device_shutdown,
  output logic                          main_group_drivers_on,
  output logic                          aux_group_drivers_on,
  output logic                          indicator_driver_on,
  output logic                          sink_fifty_three_to_main,
  output logic                          sink_sixty_two_to_main
);
  import led_i2c_pkg::*;

  // --------------------------------------------------------------------------
  // Register decoding helpers
  // --------------------------------------------------------------------------
  function automatic logic index_known(input logic [7:0] idx);
    index_known = (idx == `IDX_GROUP_ENABLE) || (idx == `IDX_RAMP_STEP) ||
                  (idx == `IDX_VF_MON_DELAY) || (idx == `IDX_MAIN_BRIGHT) ||
                  (idx == `IDX_AUX_BRIGHT) || (idx == `IDX_IND_BRIGHT);
  endfunction

  function automatic logic [7:0] read_reg(input logic [7:0] idx, input reg_bank_t bank);
    read_reg = 8'h00;
    unique case (idx)
      `IDX_GROUP_ENABLE: read_reg = bank.group_enable_and_assign;
      `IDX_RAMP_STEP:    read_reg = bank.ramp_step_time;
      `IDX_VF_MON_DELAY: read_reg = bank.forward_voltage_monitor_delay;
      `IDX_MAIN_BRIGHT:  read_reg = bank.main_group_brightness;
      `IDX_AUX_BRIGHT:   read_reg = bank.aux_group_brightness;
      `IDX_IND_BRIGHT:   read_reg = bank.indicator_brightness;
      default:           read_reg = 8'h00;
    endcase
  endfunction

  function automatic reg_bank_t reset_bank();
    reset_bank.group_enable_and_assign       = `RST_GROUP_ENABLE;
    reset_bank.ramp_step_time                = `RST_RAMP_STEP;
    reset_bank.forward_voltage_monitor_delay = `RST_VF_MON_DELAY;
    reset_bank.main_group_brightness         = `RST_MAIN_BRIGHT;
    reset_bank.aux_group_brightness          = `RST_AUX_BRIGHT;
    reset_bank.indicator_brightness          = `RST_IND_BRIGHT;
  endfunction

  // --------------------------------------------------------------------------
  // Pin synchronisation
  // --------------------------------------------------------------------------
  // Only events from the second synchroniser stage reach the protocol logic.
  bus_events_t ev;

  bus_pin_sync u_sync (
    .mclk                 (mclk),
    .srst                 (srst),
    .scl_in               (scl_in),
    .sda_in               (sda_in),
    .hardware_reset_pin_n (hardware_reset_pin_n),
    .events               (ev)
  );

  // --------------------------------------------------------------------------
  // Protocol state
  // --------------------------------------------------------------------------
  state_t     state_q;
  state_t     state_d;
  byte_kind_t kind_q;
  byte_kind_t kind_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic [7:0] index_q;
  logic [7:0] index_d;
  logic       rw_q;
  logic       rw_d;
  logic       oe_q;
  logic       oe_d;
  logic       busy_q;
  logic       busy_d;
  reg_bank_t  bank_q;
  reg_bank_t  bank_d;

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  // The byte for a read is fetched once here and used by ST_ACK and ST_TX_ACK.
  logic [7:0] rd_byte;

  always_comb begin
    rd_byte = read_reg(index_q, bank_q);
  end

  always_comb begin
    state_d = state_q;
    kind_d  = kind_q;
    cnt_d   = cnt_q;
    shift_d = shift_q;
    index_d = index_q;
    rw_d    = rw_q;
    oe_d    = oe_q;
    busy_d  = busy_q;
    bank_d  = bank_q;
    if (!ev.reset_pin_n) begin
      // The reset pin shuts the port down and restores power-on values.
      state_d = ST_IDLE;
      oe_d    = 1'b0;
      busy_d  = 1'b0;
      cnt_d   = 4'h0;
      index_d = 8'h00;
      bank_d  = reset_bank(); // RL14
    end else if (ev.start) begin
      state_d = ST_RX; // RL5
      kind_d  = KIND_ADDR; // RL9
      cnt_d   = 4'h0;
      oe_d    = 1'b0;
      busy_d  = 1'b1; // RL4
    end else if (ev.stop) begin
      state_d = ST_IDLE;
      oe_d    = 1'b0;
      busy_d  = 1'b0; // RL4
    end else begin
      unique case (state_q)
        ST_IDLE, ST_IGNORE: begin
          // Between frames or after a foreign address the pin stays released.
          oe_d = 1'b0; // RL17
        end
        ST_RX: begin
          if (ev.scl_rise && cnt_q < `BYTE_BITS) begin
            shift_d = {shift_q[6:0], ev.sda}; // RL6
            cnt_d   = cnt_q + 4'h1;
          end else if (ev.scl_fall && cnt_q == `BYTE_BITS) begin
            // Acknowledge is driven in the low phase after the eighth bit.
            state_d = ST_ACK; // RL1
            oe_d    = 1'b1;
            unique case (kind_q)
              KIND_ADDR: begin
                rw_d = shift_q[0]; // RL11
                if (shift_q[7:1] != `CHIP_ADDR) begin // RL10
                  state_d = ST_IGNORE; // RL17
                  oe_d    = 1'b0;
                end
              end
              KIND_INDEX: begin
                index_d = shift_q; // RL12
              end
              KIND_DATA: begin
                // Further data bytes rewrite the same register.
                if (index_known(index_q)) begin // RL18
                  unique case (index_q)
                    `IDX_GROUP_ENABLE: bank_d.group_enable_and_assign = shift_q; // RL13
                    `IDX_RAMP_STEP:    bank_d.ramp_step_time = shift_q;
                    `IDX_VF_MON_DELAY: bank_d.forward_voltage_monitor_delay = shift_q;
                    `IDX_MAIN_BRIGHT:  bank_d.main_group_brightness = shift_q;
                    `IDX_AUX_BRIGHT:   bank_d.aux_group_brightness = shift_q;
                    default:           bank_d.indicator_brightness = shift_q;
                  endcase
                end
              end
              default: state_d = ST_IGNORE;
            endcase
          end
        end
        ST_ACK: begin
          // Data held low through the whole ninth pulse; after it, released, or for a read set to the first data bit.
          if (ev.scl_fall) begin // RL8
            cnt_d = 4'h0;
            if (kind_q == KIND_ADDR && rw_q == `DIR_READ) begin
              state_d = ST_TX; // RL11
              shift_d = rd_byte;
              oe_d    = ~rd_byte[7];
            end else begin
              state_d = ST_RX;
              oe_d    = 1'b0; // RL7
              kind_d  = (kind_q == KIND_ADDR) ? KIND_INDEX : KIND_DATA;
            end
          end
        end
        ST_TX: begin
          // Each read bit is set up in the low phase after a clock fall.
          if (ev.scl_fall) begin // RL1
            shift_d = {shift_q[6:0], 1'b0};
            cnt_d   = cnt_q + 4'h1;
            if (cnt_q == 4'h7) begin
              state_d = ST_TX_ACK;
              oe_d    = 1'b0;
              cnt_d   = 4'h0;
            end else begin
              oe_d = ~shift_q[6]; // RL6
            end
          end
        end
        ST_TX_ACK: begin
          // A high level in the ninth pulse ends the read; low asks for more.
          if (ev.scl_rise) begin
            if (ev.sda) begin
              state_d = ST_IGNORE;
            end else begin
              cnt_d = 4'h1;
            end
          end else if (ev.scl_fall && cnt_q == 4'h1) begin
            state_d = ST_TX;
            cnt_d   = 4'h0;
            shift_d = rd_byte;
            oe_d    = ~rd_byte[7];
          end
        end
        default: state_d = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_q <= ST_IDLE;
      kind_q  <= KIND_ADDR;
      cnt_q   <= 4'h0;
      shift_q <= 8'h00;
      index_q <= 8'h00;
      rw_q    <= `DIR_WRITE;
      oe_q    <= 1'b0;
      busy_q  <= 1'b0;
      bank_q  <= reset_bank(); // RL14
    end else begin
      state_q <= state_d;
      kind_q  <= kind_d;
      cnt_q   <= cnt_d;
      shift_q <= shift_d;
      index_q <= index_d;
      rw_q    <= rw_d;
      oe_q    <= oe_d;
      busy_q  <= busy_d;
      bank_q  <= bank_d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  // Shutdown follows the synchronised reset pin one cycle later.
  logic shut_q;
  logic shut_d;

  always_comb begin
    shut_d = ~ev.reset_pin_n;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      shut_q <= 1'b0;
    end else begin
      shut_q <= shut_d;
    end
  end

  // The data pin is open drain, so only its enable ever moves.
  always_comb begin
    sda_out                  = 1'b0;
    sda_oe                   = oe_q;
    regs                     = bank_q;
    bus_busy                 = busy_q;
    device_shutdown          = shut_q;
    main_group_drivers_on    = bank_q.group_enable_and_assign[`BIT_MAIN_ON]; // RL15
    aux_group_drivers_on     = bank_q.group_enable_and_assign[`BIT_AUX_ON];
    indicator_driver_on      = bank_q.group_enable_and_assign[`BIT_IND_ON];
    sink_fifty_three_to_main = bank_q.group_enable_and_assign[`BIT_SINK53_MAIN]; // RL16
    sink_sixty_two_to_main   = bank_q.group_enable_and_assign[`BIT_SINK62_MAIN]; // RL16
  end

endmodule

// ==== tb/i2c_master_model.sv ====
// Purpose: Serial bus master that drives the clock and pulls the data line.
// Assumes: Tasks are entered just after an mclk edge; delays keep that phase.
// Notes:   Clock idles high between frames; a released data line reads high.
`timescale 1ns/1ps
module i2c_master_model (
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic start();
    #16 sda_pull = 1'b0;
    #16 scl = 1'b1;
    #16 sda_pull = 1'b1;
    #16 scl = 1'b0;
  endtask
  task automatic stop();
    #16 sda_pull = 1'b1;
    #16 scl = 1'b1;
    #16 sda_pull = 1'b0;
    #16;
  endtask
  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #16 sda_pull = ~b[i];
      #16 scl = 1'b1;
      #32 scl = 1'b0;
    end
    #16 sda_pull = 1'b0;
    #16 scl = 1'b1;
    #16 ack = ~sda;
    #16 scl = 1'b0;
  endtask
  task automatic recv(input logic nack, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      #16 sda_pull = 1'b0;
      #16 scl = 1'b1;
      #16 b[i] = sda;
      #16 scl = 1'b0;
    end
    #16 sda_pull = ~nack;
    #16 scl = 1'b1;
    #32 scl = 1'b0;
  endtask
endmodule

// ==== tb/led_i2c_regs_bench.sv ====
// Purpose: Self-checking bench of the LED driver register port.
// Assumes: The master model drives the serial pins; the data line has a pull-up.
// Notes:   Expected bank values come from the power-on table and the writes made.
`timescale 1ns/1ps
`include "led_i2c_cfg.svh"
module led_i2c_regs_bench;
  import led_i2c_pkg::*;
  localparam logic [47:0] RST = {`RST_GROUP_ENABLE, `RST_RAMP_STEP, `RST_VF_MON_DELAY,
                                 `RST_MAIN_BRIGHT, `RST_AUX_BRIGHT, `RST_IND_BRIGHT};
  localparam logic [47:0] IDX = {`IDX_GROUP_ENABLE, `IDX_RAMP_STEP, `IDX_VF_MON_DELAY,
                                 `IDX_MAIN_BRIGHT, `IDX_AUX_BRIGHT, `IDX_IND_BRIGHT};
  localparam logic [47:0] VAL = 48'h1d_03_01_1f_07_02;
  logic       mclk, srst, hw_n, sda_oe, sda_out, busy, shut, ack, scl, m_pull;
  logic [4:0] outs;
  logic [7:0] rb;
  reg_bank_t  regs, want;
  int         err_total, checks;
  wire        sda = !(m_pull || (sda_oe && !sda_out));
  led_i2c_regs dut_u (.mclk(mclk), .srst(srst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .hardware_reset_pin_n(hw_n), .regs(regs),
    .bus_busy(busy), .device_shutdown(shut), .main_group_drivers_on(outs[0]),
    .aux_group_drivers_on(outs[1]), .indicator_driver_on(outs[2]),
    .sink_fifty_three_to_main(outs[3]), .sink_sixty_two_to_main(outs[4]));
  i2c_master_model m_u (.scl(scl), .sda_pull(m_pull), .sda(sda));
  task automatic chk(input logic [47:0] got, exp_v, input string what);
    checks++;
    if (got !== exp_v) begin
      err_total++;
      $display("mismatch at %0t ns: %s got %h want %h", $time, what, got, exp_v);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] idx, dat, input logic acked);
    m_u.start();
    m_u.send({a, `DIR_WRITE}, ack);
    chk(48'(ack), 48'(acked), "address ack");
    m_u.send(idx, ack);
    chk(48'(ack), 48'(acked), "index ack");
    m_u.send(dat, ack);
    chk(48'(ack), 48'(acked), "data ack");
    m_u.stop();
    idle(4);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    #100000;
    err_total++;
    $display("mismatch at %0t ns: watchdog expired", $time);
    complete_run();
  end
  initial begin
    srst = 1'b1;
    hw_n = 1'b1;
    repeat (4) @(posedge mclk);
    #1 srst = 1'b0;
    idle(4);
    want = RST;
    chk(regs, want, "power-on values");
    for (int i = 0; i < 6; i++) begin
      wr(`CHIP_ADDR, IDX[47-8*i -: 8], VAL[47-8*i -: 8], 1'b1);
      want[47-8*i -: 8] = VAL[47-8*i -: 8];
      chk(regs, want, "register write");
    end
    chk(48'(outs), 48'(VAL[44:40]), "driver enables");
    wr(`CHIP_ADDR, `IDX_GROUP_ENABLE, 8'h02, 1'b1);
    want.group_enable_and_assign = 8'h02;
    chk(48'(outs), 48'h02, "group assignment");
    $display("test writes done");
    wr(7'h37, `IDX_MAIN_BRIGHT, 8'h55, 1'b0);
    chk(regs, want, "foreign address");
    wr(`CHIP_ADDR, 8'h30, 8'h55, 1'b1);
    chk(regs, want, "unknown index");
    $display("test refusals done");
    m_u.start();
    m_u.send({`CHIP_ADDR, `DIR_WRITE}, ack);
    m_u.send(`IDX_MAIN_BRIGHT, ack);
    chk(48'(busy), 48'h1, "busy in transfer");
    m_u.start();
    m_u.send({`CHIP_ADDR, `DIR_WRITE}, ack);
    m_u.send(`IDX_AUX_BRIGHT, ack);
    m_u.send(8'h44, ack);
    m_u.stop();
    idle(8);
    want.aux_group_brightness = 8'h44;
    chk(regs, want, "repeated start");
    chk(48'(busy), 48'h0, "free after stop");
    m_u.start();
    m_u.send({`CHIP_ADDR, `DIR_READ}, ack);
    chk(48'(ack), 48'h1, "read address ack");
    m_u.recv(1'b0, rb);
    chk(48'(rb), 48'h44, "read first byte");
    m_u.recv(1'b1, rb);
    m_u.stop();
    idle(4);
    chk(48'(rb), 48'h44, "read back");
    $display("test restart and read done");
    hw_n = 1'b0;
    idle(8);
    chk(regs, RST, "pin reset values");
    chk(48'(shut), 48'h1, "shutdown");
    hw_n = 1'b1;
    idle(8);
    chk(48'(shut), 48'h0, "shutdown released");
    wr(`CHIP_ADDR, `IDX_IND_BRIGHT, 8'h05, 1'b1);
    want = RST;
    want.indicator_brightness = 8'h05;
    chk(regs, want, "write after pin reset");
    $display("test pin reset done");
    complete_run();
  end
endmodule

// ==== tb/led_i2c_regs_checker.sv ====
// Purpose: Protocol checks at the pins of the LED driver register port.
// Assumes: The serial clock phases last at least eight mclk cycles.
// Notes:   Tracks bytes from raw pin edges to know when an ack is due.
`timescale 1ns/1ps
`include "led_i2c_cfg.svh"
module led_i2c_regs_checker (
  input wire logic                   mclk,
  input wire logic                   srst,
  input wire logic                   scl_in,
  input wire logic                   sda_in,
  input wire logic                   sda_out,
  input wire logic                   sda_oe,
  input wire logic                   hardware_reset_pin_n,
  input wire led_i2c_pkg::reg_bank_t regs,
  input wire logic                   bus_busy,
  input wire logic                   device_shutdown,
  input wire logic                   main_group_drivers_on,
  input wire logic                   aux_group_drivers_on,
  input wire logic                   indicator_driver_on,
  input wire logic                   sink_fifty_three_to_main,
  input wire logic                   sink_sixty_two_to_main
);
  import led_i2c_pkg::*;
  localparam logic [47:0] RST_BANK = {`RST_GROUP_ENABLE, `RST_RAMP_STEP, `RST_VF_MON_DELAY,
                                      `RST_MAIN_BRIGHT, `RST_AUX_BRIGHT, `RST_IND_BRIGHT};
  logic       scl_q, sda_q, first_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic [1:0] mode_q;
  wire rise      = scl_in && !scl_q;
  wire fall      = !scl_in && scl_q;
  wire start_det = scl_in && scl_q && sda_q && !sda_in;
  wire stop_det  = scl_in && scl_q && !sda_q && sda_in;
  wire byte_end  = fall && cnt_q == 4'h8;
  wire addr_ok   = sh_q[7:1] == `CHIP_ADDR;
  wire ack_due   = byte_end && (first_q ? addr_ok : mode_q == 2'h1);
  // Mode after the address byte: 1 write, 2 foreign, 3 read.
  always_ff @(posedge mclk) begin
    scl_q <= scl_in;
    sda_q <= sda_in;
    if (srst || !hardware_reset_pin_n) begin
      cnt_q   <= 4'h0;
      first_q <= 1'b0;
      mode_q  <= 2'h0;
    end else if (start_det) begin
      cnt_q   <= 4'h0;
      first_q <= 1'b1;
      mode_q  <= 2'h0;
    end else begin
      if (rise) begin
        cnt_q <= (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
        sh_q  <= {sh_q[6:0], sda_in};
      end
      if (byte_end && first_q) begin
        first_q <= 1'b0;
        mode_q  <= addr_ok ? (sh_q[0] ? 2'h3 : 2'h1) : 2'h2;
      end
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  a_enable_map: assert property ({indicator_driver_on, aux_group_drivers_on,
    main_group_drivers_on} == regs.group_enable_and_assign[2:0]) else $error("enable map");
  a_sink_map: assert property ({sink_sixty_two_to_main, sink_fifty_three_to_main}
    == regs.group_enable_and_assign[4:3]) else $error("sink map");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data moved with clock high");
  a_busy_start: assert property (start_det && hardware_reset_pin_n |-> ##[1:8] bus_busy)
    else $error("busy missing");
  a_busy_stop: assert property (stop_det |-> ##[1:8] !bus_busy)
    else $error("busy after stop");
  a_ack_held: assert property ($rose(sda_oe) |-> sda_oe[*8] ##0 !sda_out)
    else $error("ack too short");
  a_ack_due: assert property (ack_due |-> ##[1:8] sda_oe)
    else $error("ack missing");
  a_quiet_foreign: assert property (mode_q == 2'h2 |-> !sda_oe)
    else $error("foreign address answered");
  a_srst_values: assert property ($fell(srst) |-> regs == RST_BANK)
    else $error("bad reset values");
  a_pin_reset: assert property (!hardware_reset_pin_n [*5] |->
    device_shutdown && regs == RST_BANK) else $error("pin reset failed");
  c_ack: cover property (ack_due);
  c_foreign: cover property (mode_q == 2'h2);
  c_restart: cover property (start_det && bus_busy);
  c_pin: cover property (!hardware_reset_pin_n && device_shutdown);
endmodule
bind led_i2c_regs led_i2c_regs_checker checker_u (.mclk(mclk), .srst(srst),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .hardware_reset_pin_n(hardware_reset_pin_n), .regs(regs), .bus_busy(bus_busy),
  .device_shutdown(device_shutdown), .main_group_drivers_on(main_group_drivers_on),
  .aux_group_drivers_on(aux_group_drivers_on), .indicator_driver_on(indicator_driver_on),
  .sink_fifty_three_to_main(sink_fifty_three_to_main),
  .sink_sixty_two_to_main(sink_sixty_two_to_main));
